//--- logic/etc_defines.svh
// timing-free constants for the event transfer controller
// assumes inclusion by the package, the core and the bench
`ifndef ETC_DEFINES_SVH
`define ETC_DEFINES_SVH
`define ETC_MAX_UNITS 256
`define ETC_VBR_LOW_W 10
`define ETC_VBR_HIGH_W 22
`define ETC_VEC_W 8
`define ETC_DESC_WORDS 4
`define ETC_FIFO_DEPTH 4
`define ETC_SZ_BYTE 2'h0
`define ETC_SZ_HALF 2'h1
`define ETC_SZ_WORD 2'h2
`define ETC_MODE_NORMAL 2'h0
`define ETC_MODE_REPEAT 2'h1
`define ETC_MODE_BLOCK 2'h2
`define ETC_F_MODE_LSB 30
`define ETC_F_SIZE_LSB 28
`define ETC_F_SRC_INC 27
`define ETC_F_DST_INC 26
`define ETC_F_RPT_DST 25
`endif

//--- logic/etc_pkg.sv
// types for the event transfer controller
// assumes etc_defines.svh is on the include path
`include "etc_defines.svh"
package etc_pkg;
    typedef enum logic [1:0] {
        etc_normal_type_v,
        etc_repeat_type_v,
        etc_block_type_v,
        etc_rsvd_type_v
    } etc_mode_type;
    typedef enum logic [2:0] {
        ETC_IDLE, ETC_FETCH, ETC_READ, ETC_WRITE, ETC_WAITDRAIN, ETC_STORE
    } etc_state_type;
endpackage : etc_pkg

//--- logic/etc_fifo.sv
// small valid/ready fifo carrying read data toward the write side
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module etc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("etc_fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge core_clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
    fifo_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : etc_fifo

//--- logic/etc_core.sv
// event transfer controller: activations fetch a descriptor, move units
// assumes a simple single-cycle-grant memory port, descriptor words in the grant cycle, unit read data one cycle later
// Contract
// - normal mode moves one unit per activation
// - repeat mode also moves one unit
// - repeat count reached reloads start address
// - repeat size reaches 256 units
// - block mode moves whole block per activation
// - block length one to 256 units
// - unit is byte, halfword or word
// - vector base is 10-bit low, 22-bit high
`timescale 1ns/1ps
`include "etc_defines.svh"
module etc_core #(
    parameter int FIFO_DEPTH = `ETC_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic act_req,
    input wire logic [`ETC_VEC_W-1:0] act_vector,
    output logic act_ack,
    input wire logic [`ETC_VBR_LOW_W-1:0] vbr_low,
    input wire logic [`ETC_VBR_HIGH_W-1:0] vbr_high,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    input wire logic mem_gnt,
    input wire logic [31:0] mem_rdata,
    output logic busy,
    output logic done
);
    initial begin
        if (FIFO_DEPTH < 2)
            $error("etc_core fifo depth too small");
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] unit_step(input logic [1:0] sz);
        unit_step = (sz == `ETC_SZ_BYTE) ? 32'h1 : (sz == `ETC_SZ_HALF) ? 32'h2 : 32'h4;
    endfunction : unit_step
    function automatic logic [31:0] bump(input logic [31:0] a, input logic inc, input logic [1:0] sz);
        bump = inc ? a + unit_step(sz) : a;
    endfunction : bump
    // start of a repeat area, seen from an address already advanced past n units
    function automatic logic [31:0] rewind(input logic [31:0] a, input logic inc, input logic [1:0] sz,
                                           input logic [8:0] n);
        rewind = inc ? a - {23'h0, n} * unit_step(sz) : a;
    endfunction : rewind
    // ==========================================================
    // state
    etc_pkg::etc_state_type state;
    logic [31:0] table_base;
    logic [31:0] desc_ptr;
    logic [1:0] fetch_idx;
    logic [31:0] cfg;
    logic [31:0] src;
    logic [31:0] dst;
    logic [8:0] count;
    logic [8:0] reload;
    logic rd_pending;
    logic [1:0] mode;
    logic [1:0] usize;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic last_unit;
    assign table_base = {vbr_high, vbr_low};
    assign mode = cfg[`ETC_F_MODE_LSB +: 2];
    assign usize = cfg[`ETC_F_SIZE_LSB +: 2];
    // count field 0 encodes 256 so the full range fits 8 bits
    assign last_unit = (count == 9'h1);
    etc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    assign fifo_in_valid = rd_pending;
    assign fifo_out_ready = (state == etc_pkg::ETC_WRITE) && mem_gnt && mem_we;
    // ==========================================================
    // sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= etc_pkg::ETC_IDLE;
            fetch_idx <= 2'h0;
            desc_ptr <= 32'h0;
            act_ack <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            rd_pending <= 1'b0;
        end else begin
            act_ack <= 1'b0;
            done <= 1'b0;
            rd_pending <= 1'b0;
            unique case (state)
                etc_pkg::ETC_IDLE: begin
                    if (act_req) begin
                        desc_ptr <= table_base + {act_vector, 4'h0};
                        fetch_idx <= 2'h0;
                        act_ack <= 1'b1;
                        busy <= 1'b1;
                        state <= etc_pkg::ETC_FETCH;
                    end
                end
                etc_pkg::ETC_FETCH: begin
                    if (mem_gnt) begin
                        fetch_idx <= fetch_idx + 2'h1;
                        if (fetch_idx == 2'h3)
                            state <= etc_pkg::ETC_READ;
                    end
                end
                etc_pkg::ETC_READ: begin
                    // fifo space reserved before issuing so read data never drops
                    if (mem_gnt && fifo_in_ready) begin
                        rd_pending <= 1'b1;
                        state <= etc_pkg::ETC_WRITE;
                    end
                end
                etc_pkg::ETC_WRITE: begin
                    if (mem_gnt && fifo_out_valid) begin
                        if (last_unit || mode != `ETC_MODE_BLOCK)
                            state <= etc_pkg::ETC_STORE;
                        else
                            state <= etc_pkg::ETC_READ;
                    end
                end
                etc_pkg::ETC_STORE: begin
                    if (mem_gnt) begin
                        fetch_idx <= fetch_idx + 2'h1;
                        if (fetch_idx == 2'h3) begin
                            done <= 1'b1;
                            busy <= 1'b0;
                            state <= etc_pkg::ETC_IDLE;
                        end
                    end
                end
                default: state <= etc_pkg::ETC_IDLE;
            endcase
        end
    end
    // ==========================================================
    // descriptor words: cfg, src, dst, count/reload
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg <= 32'h0;
            src <= 32'h0;
            dst <= 32'h0;
            count <= 9'h0;
            reload <= 9'h0;
        end else if (state == etc_pkg::ETC_FETCH && mem_gnt) begin
            unique case (fetch_idx)
                2'h0: cfg <= mem_rdata;
                2'h1: src <= mem_rdata;
                2'h2: dst <= mem_rdata;
                2'h3: begin
                    count <= (mem_rdata[7:0] == 8'h0) ? 9'h100 : {1'b0, mem_rdata[7:0]};
                    reload <= (mem_rdata[15:8] == 8'h0) ? 9'h100 : {1'b0, mem_rdata[15:8]};
                end
            endcase
        end else if (state == etc_pkg::ETC_READ && mem_gnt && fifo_in_ready) begin
            src <= bump(src, cfg[`ETC_F_SRC_INC], usize);
        end else if (state == etc_pkg::ETC_WRITE && mem_gnt && fifo_out_valid) begin
            dst <= bump(dst, cfg[`ETC_F_DST_INC], usize);
            if (mode == `ETC_MODE_REPEAT && last_unit) begin
                count <= reload;
                // only the repeating side returns to its start; the start is recovered from the
                // advanced address because the written-back descriptor holds only the moving one
                if (cfg[`ETC_F_RPT_DST])
                    dst <= rewind(bump(dst, cfg[`ETC_F_DST_INC], usize), cfg[`ETC_F_DST_INC], usize, reload);
                else
                    src <= rewind(src, cfg[`ETC_F_SRC_INC], usize, reload);
            end else if (!(mode == `ETC_MODE_NORMAL && count == 9'h0)) begin
                count <= count - 9'h1;
            end
        end
    end
    // ==========================================================
    // memory port, registered from state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0;
            mem_size <= `ETC_SZ_WORD;
            mem_wdata <= 32'h0;
        end else begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_size <= `ETC_SZ_WORD;
            mem_wdata <= 32'h0;
            mem_addr <= 32'h0;
            // a granted access is followed by one idle cycle: the index, address and state it
            // advanced are not settled yet, so a back-to-back request would repeat the old access
            if (!(mem_req && mem_gnt)) begin
                unique case (state)
                    etc_pkg::ETC_FETCH: begin
                        mem_req <= 1'b1;
                        mem_addr <= desc_ptr + {28'h0, fetch_idx, 2'h0};
                    end
                    etc_pkg::ETC_READ: begin
                        mem_req <= fifo_in_ready;
                        mem_addr <= src;
                        mem_size <= usize;
                    end
                    etc_pkg::ETC_WRITE: begin
                        mem_req <= fifo_out_valid;
                        mem_we <= 1'b1;
                        mem_addr <= dst;
                        mem_size <= usize;
                        mem_wdata <= fifo_out_data;
                    end
                    etc_pkg::ETC_STORE: begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= desc_ptr + {28'h0, fetch_idx, 2'h0};
                        mem_wdata <= (fetch_idx == 2'h0) ? cfg : (fetch_idx == 2'h1) ? src :
                                     (fetch_idx == 2'h2) ? dst : {16'h0, reload[7:0], count[7:0]};
                    end
                    default: ;
                endcase
            end
        end
    end
    // ==========================================================
    // checks
    normal_one_unit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == etc_pkg::ETC_WRITE && mem_gnt && fifo_out_valid && mode == `ETC_MODE_NORMAL)
        |=> state == etc_pkg::ETC_STORE) else $error("normal mode kept moving");
    repeat_one_unit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == etc_pkg::ETC_WRITE && mem_gnt && fifo_out_valid && mode == `ETC_MODE_REPEAT)
        |=> state == etc_pkg::ETC_STORE) else $error("repeat mode kept moving");
    repeat_reload_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == etc_pkg::ETC_WRITE && mem_gnt && fifo_out_valid && mode == `ETC_MODE_REPEAT
         && last_unit && !cfg[`ETC_F_RPT_DST] && cfg[`ETC_F_SRC_INC])
        |=> count == $past(reload) && src + {23'h0, count} * unit_step(usize) == $past(src))
        else $error("no reload");
    count_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        count <= 9'h100) else $error("count beyond 256");
    block_continue_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == etc_pkg::ETC_WRITE && mem_gnt && fifo_out_valid && mode == `ETC_MODE_BLOCK && !last_unit)
        |=> state == etc_pkg::ETC_READ) else $error("block stopped early");
    unit_size_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req |-> mem_size != 2'h3) else $error("illegal unit size");
    base_join_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        table_base[9:0] == vbr_low && table_base[31:10] == vbr_high) else $error("bad base");
    vector_index_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == etc_pkg::ETC_IDLE && act_req) |=> desc_ptr == table_base + {$past(act_vector), 4'h0})
        else $error("bad descriptor pointer");
endmodule : etc_core

//--- bench/etc_mem_model.sv
// memory partner of the event transfer controller: word array with lane writes
// assumes the controller holds a request until granted and reads data one cycle after a data grant
`timescale 1ns/1ps
module etc_mem_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_wdata,
    output logic mem_gnt,
    output logic [31:0] mem_rdata
);
    // ==========================================
    // storage and answer
    logic [31:0] mem [0:2047];
    logic [31:0] last_rd;
    logic rd_pending;
    logic [3:0] lane;
    // no grant in the data cycle after a read, so the read data never gets overtaken
    assign mem_gnt = mem_req && !rd_pending && !stall;
    always_comb begin
        if (mem_req && !mem_we && !rd_pending) begin
            mem_rdata = mem[mem_addr[12:2]];
        end else if (rd_pending) begin
            mem_rdata = last_rd;
        end else begin
            // released bus shows a changed value, never the stale one
            mem_rdata = ~last_rd;
        end
    end
    always_comb begin
        case (mem_size)
            2'h0: lane = 4'h1 << mem_addr[1:0];
            2'h1: lane = mem_addr[1] ? 4'hc : 4'h3;
            default: lane = 4'hf;
        endcase
    end
    always @(posedge core_clk) begin
        rd_pending <= !sys_rst && mem_gnt && !mem_we;
        if (sys_rst) begin
            last_rd <= 32'h0;
        end else if (mem_gnt && !mem_we) begin
            last_rd <= mem_rdata;
        end
        if (!sys_rst && mem_gnt && mem_we) begin
            for (int b = 0; b < 4; b++) begin
                if (lane[b]) mem[mem_addr[12:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
            end
        end
    end
endmodule : etc_mem_model

//--- bench/tb.sv
// self-checking bench of the event transfer controller
// assumes etc_defines.svh on the include path; table lives above 64 KiB, data below
`timescale 1ns/1ps
`include "etc_defines.svh"
module tb;
    localparam logic [31:0] VBR = 32'h000b_5600;
    logic core_clk, sys_rst, act_req, act_ack, busy, done, stall;
    logic [7:0] act_vector;
    logic [9:0] vbr_low;
    logic [21:0] vbr_high;
    logic mem_req, mem_we, mem_gnt;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, tab, d;
    logic [1:0] mem_size;
    logic [65:0] exp_q[$];
    logic [65:0] e;
    int fails, num_checks, seed, i, sz;

    etc_core #(.FIFO_DEPTH(4)) etc_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .act_req(act_req),
        .act_vector(act_vector), .act_ack(act_ack), .vbr_low(vbr_low), .vbr_high(vbr_high),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .busy(busy), .done(done));
    etc_mem_model etc_mem_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .stall(stall),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // random grant stalls make the partner slow at times
    always @(negedge core_clk) stall = ($random(seed) & 3) == 0;

    // ==========================================
    // checking
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic [31:0] mask(input logic [1:0] s);
        return (s == 2'h0) ? 32'h0000_00ff : (s == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction : mask
    always @(posedge core_clk) begin
        if (!sys_rst && mem_req && mem_gnt) begin
            if (mem_addr[31:16] != 16'h0) begin
                cmp({mem_addr[31:4], 4'h0}, tab);
            end else if (mem_we) begin
                if (exp_q.size() == 0) begin
                    // a write nobody asked for
                    cmp(mem_addr, 32'hffff_ffff);
                end else begin
                    e = exp_q.pop_front();
                    cmp({30'h0, mem_size}, {30'h0, e[65:64]});
                    cmp(mem_addr, e[63:32]);
                    cmp(mem_wdata & mask(e[65:64]), e[31:0] & mask(e[65:64]));
                end
            end
        end
    end

    // ==========================================
    // stimulus
    task automatic desc(input int vec, input logic [1:0] md, input logic [1:0] s, input logic [2:0] fl,
                        input logic [31:0] src, input logic [31:0] dst, input logic [15:0] cnt);
        int k;
        k = int'(VBR[12:2]) + vec * 4;
        etc_mem_model_i.mem[k] = {md, s, fl, 25'h0};
        etc_mem_model_i.mem[k+1] = src;
        etc_mem_model_i.mem[k+2] = dst;
        etc_mem_model_i.mem[k+3] = {16'h0, cnt};
    endtask : desc
    task automatic put(input logic [1:0] s, input logic [31:0] a, input logic [31:0] v);
        exp_q.push_back({s, a, v});
    endtask : put
    task automatic act(input int vec);
        int n;
        int m;
        tab = VBR + 32'(vec * 16);
        @(negedge core_clk);
        act_req = 1'b1;
        act_vector = vec[7:0];
        for (n = 0; n < 50 && act_ack !== 1'b1; n++) @(negedge core_clk);
        act_req = 1'b0;
        cmp({31'h0, busy}, 32'h1);
        for (m = 0; m < 6000 && done !== 1'b1; m++) @(negedge core_clk);
        cmp({31'h0, busy}, 32'h0);
        if (n == 50 || m == 6000) begin
            fails++;
            summarize();
        end
        cmp(32'(exp_q.size()), 32'h0);
    endtask : act

    initial begin
        seed = 30;
        fails = 0;
        num_checks = 0;
        act_req = 1'b0;
        act_vector = 8'h0;
        vbr_low = VBR[9:0];
        vbr_high = VBR[31:10];
        sys_rst = 1'b1;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        // aligned units only: lane 0 carries the data whatever the justification
        for (sz = 0; sz < 3; sz++) begin
            d = $random(seed);
            etc_mem_model_i.mem[4] = d;
            desc(1, `ETC_MODE_NORMAL, sz[1:0], 3'h0, 32'h10, 32'h20, 16'h0003);
            put(sz[1:0], 32'h20, d);
            act(1);
        end
        for (i = 0; i < 2; i++) etc_mem_model_i.mem[64+i] = $random(seed);
        desc(2, `ETC_MODE_REPEAT, `ETC_SZ_WORD, 3'h6, 32'h100, 32'h200, 16'h0202);
        for (i = 0; i < 3; i++) begin
            put(2'h2, 32'(32'h200 + i * 4), etc_mem_model_i.mem[64 + i % 2]);
            act(2);
        end
        desc(3, `ETC_MODE_REPEAT, `ETC_SZ_WORD, 3'h3, 32'h100, 32'h400, 16'h0000);
        for (i = 0; i < 257; i++) begin
            put(2'h2, 32'(32'h400 + (i % 256) * 4), etc_mem_model_i.mem[64]);
            act(3);
        end
        for (i = 0; i < 256; i++) etc_mem_model_i.mem[i] = $random(seed);
        for (sz = 1; sz <= 256; sz += 255) begin
            desc(0, `ETC_MODE_BLOCK, `ETC_SZ_WORD, 3'h6, 32'h0, 32'h800, {sz[7:0], sz[7:0]});
            for (i = 0; i < sz; i++) put(2'h2, 32'(32'h800 + i * 4), etc_mem_model_i.mem[i]);
            act(0);
        end
        summarize();
    end
endmodule : tb
